// >>> rtl/sleep_ctrl_pkg.sv
// package for the sleep-mode clock gating controller
// shared by the controller top and its wake level filter
package sleep_ctrl_pkg;

  // ********************************************
  // control register layout and reset values
  // ********************************************
  localparam int unsigned SLEEP_ENABLE_BIT = 5;
  localparam int unsigned MODE_SELECT_HI_BIT = 4;
  localparam int unsigned MODE_SELECT_LO_BIT = 3;
  localparam logic [7:0] CORE_CTRL_RESET = 8'h00;

  // ********************************************
  // sleep mode codes
  // ********************************************
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_NOISE_RED = 2'b01,
    MODE_POWER_DOWN = 2'b10,
    MODE_STANDBY = 2'b11
  } sleep_mode_e;

  // ********************************************
  // timing constants
  // ********************************************
  localparam int unsigned WAKE_HALT_CYCLES = 4;
  localparam int unsigned STANDBY_WAKE_CYCLES = 6;
  localparam int unsigned LEVEL_SAMPLES = 2;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // nominal watchdog oscillator period, ns
  localparam int unsigned WDOG_OSC_PERIOD_NS = 1000;
  localparam int unsigned WDOG_TICK_CYCLES = WDOG_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_WIDTH = 16;

endpackage

// >>> rtl/wake_level_filter.sv
// two-sample level qualifier for power-down wake-up
// assumes wd_tick is a one-cycle pulse from the watchdog oscillator domain
`timescale 1ns/1ps
module wake_level_filter
  import sleep_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic enable,
  input wire logic wd_tick,
  input wire logic level_in,
  output logic qualified
);

  logic [1:0] samples_q;

  // shift in one sample per watchdog tick; cleared when not armed
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      samples_q <= 2'h0;
    else if (!enable)
      samples_q <= 2'h0;
    else if (wd_tick)
      samples_q <= {samples_q[0], level_in};
  end

  // both samples must show the level, and it must still be there
  assign qualified = enable && (&samples_q) && level_in;

endmodule

// >>> rtl/sleep_ctrl.sv
// sleep-mode controller: mode selection, clock gating, wake qualification
// assumes core, interrupt system and wake sources share clk_sys
`timescale 1ns/1ps

// Overview of operation
// - sleep entered only when enable flag set and sleep instruction executes
// - two-bit select: 00 idle, 01 noise reduction, 10 power-down, 11 standby
// - interrupt wake: halt four cycles beyond start-up, then run handler
// - register file and static memory kept unchanged through sleep
// - reset during sleep wakes the core at the reset vector
// - idle stops only core and program-memory clocks
// - idle wakes on any enabled interrupt
// - enabled converter starts a conversion entering idle or noise reduction
// - noise reduction stops io, core and program-memory clocks
// - noise reduction wakes only on listed sources
// - power-down stops oscillator and all clocks, limited wake sources
// - power-down wake waits start-up delay chosen by clock-source fuses
// - level or pin-change wake sampled twice by watchdog oscillator
// - wake source gone before execution: its interrupt is not serviced
// - standby is power-down with oscillator running, wakes in six cycles
// - enabled converter stays enabled; re-enable forces an extended conversion
// - comparator off in power-down and standby unless it uses the reference
// - fuse-enabled brown-out detector stays active in all sleep states
// - enabled watchdog keeps running in all sleep states
// - voltage reference on only when brown-out, comparator or converter need it
// - input buffers off when io and converter clocks stop, except wake pins
// - sleep enable at bit 5, mode select at bits 4 and 3, reset zero
module sleep_ctrl
  import sleep_ctrl_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = 64
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] core_control_register,
  input wire logic sleep_instr,
  input wire logic any_irq_pending,
  input wire logic irq_adc_done,
  input wire logic irq_usi_start,
  input wire logic irq_nvm_ready,
  input wire logic external_interrupt_pin_level,
  input wire logic pin_change_irq,
  input wire logic wake_reset,
  input wire logic wd_tick,
  input wire logic crystal_clock_option,
  input wire logic adc_enable,
  input wire logic comparator_disable_bit,
  input wire logic comparator_uses_ref,
  input wire logic brownout_fuse_enable,
  input wire logic watchdog_enable,
  input wire logic [7:0] wake_pin_mask,
  output logic clk_cpu_en,
  output logic clk_flash_en,
  output logic clk_io_en,
  output logic clk_adc_en,
  output logic osc_en,
  output logic core_halted,
  output logic irq_service_ok,
  output logic resume_at_reset,
  output logic adc_start_conv,
  output logic adc_power,
  output logic adc_extended_conv,
  output logic comparator_power,
  output logic brownout_power,
  output logic watchdog_run,
  output logic vref_power,
  output logic [7:0] input_buf_en,
  output logic [1:0] active_mode
);

  // ********************************************
  // state and helpers
  // ********************************************
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_STARTUP = 2'b10,
    ST_HALT = 2'b11
  } ctrl_state_e;

  localparam logic [STARTUP_WIDTH-1:0] STANDBY_CNT = STARTUP_WIDTH'(STANDBY_WAKE_CYCLES);
  localparam logic [STARTUP_WIDTH-1:0] HALT_CNT = STARTUP_WIDTH'(WAKE_HALT_CYCLES);
  localparam logic [STARTUP_WIDTH-1:0] FUSE_CNT = STARTUP_WIDTH'(STARTUP_CYCLES);

  // refused at elaboration: the start-up counter must hold the figure
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << STARTUP_WIDTH))
  begin : g_bad_startup
    $error("STARTUP_CYCLES out of range");
  end

  // effective mode after the crystal check
  function automatic sleep_mode_e eff_mode(input logic [1:0] sel, input logic xtal);
    if (sel == MODE_STANDBY && !xtal)
      return MODE_POWER_DOWN;
    return sleep_mode_e'(sel);
  endfunction

  ctrl_state_e state_q;
  sleep_mode_e mode_q;
  logic [STARTUP_WIDTH-1:0] cnt_q;
  logic woke_by_reset_q;
  logic adc_en_prev_q;
  logic adc_ext_q;
  logic deep_sleep;
  logic level_wake;
  logic wake_event;
  logic sleep_go;

  assign sleep_go = sleep_instr && core_control_register[SLEEP_ENABLE_BIT];
  assign deep_sleep = (state_q == ST_SLEEP)
    && (mode_q == MODE_POWER_DOWN || mode_q == MODE_STANDBY);

  // ********************************************
  // level and pin-change qualification
  // ********************************************
  // in power-down/standby level wakes need two watchdog samples
  wake_level_filter u_filter (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .enable(deep_sleep),
    .wd_tick(wd_tick),
    .level_in(external_interrupt_pin_level || pin_change_irq),
    .qualified(level_wake)
  );

  // per-mode wake source selection; anything else is ignored
  always_comb
  begin
    wake_event = 1'b0;
    unique case (mode_q)
      MODE_IDLE: wake_event = any_irq_pending;
      MODE_NOISE_RED: wake_event = irq_adc_done || irq_usi_start || irq_nvm_ready
        || external_interrupt_pin_level || pin_change_irq;
      MODE_POWER_DOWN,
      MODE_STANDBY: wake_event = irq_usi_start || level_wake;
    endcase
  end

  // ********************************************
  // sleep state machine
  // ********************************************
  // reset during sleep is handled by the async reset itself
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_RUN;
      mode_q <= MODE_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_RUN:
          if (sleep_go)
          begin
            mode_q <= eff_mode(core_control_register[MODE_SELECT_HI_BIT:MODE_SELECT_LO_BIT],
              crystal_clock_option);
            state_q <= ST_SLEEP;
          end
        ST_SLEEP:
          if (wake_event)
          begin
            state_q <= ST_STARTUP;
            if (mode_q == MODE_POWER_DOWN)
              cnt_q <= FUSE_CNT;
            else if (mode_q == MODE_STANDBY)
              cnt_q <= STANDBY_CNT;
            else
              cnt_q <= STARTUP_WIDTH'(1);
          end
        ST_STARTUP:
          if (cnt_q <= STARTUP_WIDTH'(1))
          begin
            state_q <= ST_HALT;
            cnt_q <= HALT_CNT;
          end
          else
            cnt_q <= cnt_q - STARTUP_WIDTH'(1);
        ST_HALT:
          if (cnt_q <= STARTUP_WIDTH'(1))
            state_q <= ST_RUN;
          else
            cnt_q <= cnt_q - STARTUP_WIDTH'(1);
      endcase
    end
  end

  // reset vector indication: set by reset, cleared once software sleeps
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      woke_by_reset_q <= 1'b1;
    else if (sleep_go && state_q == ST_RUN)
      woke_by_reset_q <= 1'b0;
  end

  // ********************************************
  // clock gating and oscillator
  // ********************************************
  // storage is never reset here: only clocks stop, contents stay
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      clk_cpu_en <= 1'b1;
      clk_flash_en <= 1'b1;
      clk_io_en <= 1'b1;
      clk_adc_en <= 1'b1;
      osc_en <= 1'b1;
      core_halted <= 1'b0;
    end
    else
    begin
      core_halted <= (state_q != ST_RUN);
      clk_cpu_en <= (state_q == ST_RUN) || (state_q == ST_HALT && cnt_q <= STARTUP_WIDTH'(1));
      clk_flash_en <= (state_q == ST_RUN) || (state_q == ST_HALT && cnt_q <= STARTUP_WIDTH'(1));
      // idle keeps io and converter clocks; noise reduction only converter
      clk_io_en <= (state_q != ST_SLEEP) || (mode_q == MODE_IDLE);
      clk_adc_en <= (state_q != ST_SLEEP) || (mode_q == MODE_IDLE)
        || (mode_q == MODE_NOISE_RED);
      osc_en <= (state_q != ST_SLEEP) || (mode_q != MODE_POWER_DOWN);
    end
  end

  // ********************************************
  // wake interrupt qualification
  // ********************************************
  // the wake cause must still be present when execution resumes
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq_service_ok <= 1'b0;
    else if (state_q == ST_HALT && cnt_q <= STARTUP_WIDTH'(1))
      // deep modes: the filter is idle by now, so the raw levels decide
      irq_service_ok <= wake_event || ((mode_q == MODE_POWER_DOWN || mode_q == MODE_STANDBY)
        && (external_interrupt_pin_level || pin_change_irq));
    else
      irq_service_ok <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      resume_at_reset <= 1'b1;
    else
      resume_at_reset <= woke_by_reset_q || wake_reset;
  end

  // ********************************************
  // converter handling
  // ********************************************
  // auto start pulse on entry to idle or noise reduction
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      adc_start_conv <= 1'b0;
    else
      adc_start_conv <= sleep_go && state_q == ST_RUN && adc_enable
        && (eff_mode(core_control_register[MODE_SELECT_HI_BIT:MODE_SELECT_LO_BIT],
        crystal_clock_option) inside {MODE_IDLE, MODE_NOISE_RED});
  end

  // off-then-on sets the extended flag; the next start consumes it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      adc_en_prev_q <= 1'b0;
      adc_ext_q <= 1'b1;
    end
    else
    begin
      adc_en_prev_q <= adc_enable;
      if (adc_enable && !adc_en_prev_q)
        adc_ext_q <= 1'b1;
      else if (adc_start_conv)
        adc_ext_q <= 1'b0;
    end
  end

  // ********************************************
  // analog keep-alive and input buffers
  // ********************************************
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      adc_power <= 1'b0;
      adc_extended_conv <= 1'b1;
      comparator_power <= 1'b0;
      brownout_power <= 1'b0;
      watchdog_run <= 1'b0;
      vref_power <= 1'b0;
      input_buf_en <= 8'hFF;
      active_mode <= 2'h0;
    end
    else
    begin
      adc_power <= adc_enable;
      adc_extended_conv <= adc_ext_q;
      comparator_power <= !comparator_disable_bit
        && (!deep_sleep || comparator_uses_ref);
      brownout_power <= brownout_fuse_enable;
      watchdog_run <= watchdog_enable;
      vref_power <= brownout_fuse_enable || adc_enable
        || (!comparator_disable_bit && comparator_uses_ref);
      // both io and converter clocks stop only in power-down and standby
      input_buf_en <= deep_sleep ? wake_pin_mask : 8'hFF;
      active_mode <= mode_q;
    end
  end

endmodule

// >>> tb/sleep_ctrl_asserts.sv
// checker for sleep_ctrl: entry, clock gating, wake timing
// bound to every sleep_ctrl instance, sees its ports only
`timescale 1ns/1ps
module sleep_ctrl_asserts
  import sleep_ctrl_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = 64
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] core_control_register,
  input wire logic sleep_instr,
  input wire logic any_irq_pending,
  input wire logic crystal_clock_option,
  input wire logic adc_enable,
  input wire logic [7:0] wake_pin_mask,
  input wire logic clk_cpu_en,
  input wire logic clk_flash_en,
  input wire logic clk_io_en,
  input wire logic clk_adc_en,
  input wire logic osc_en,
  input wire logic core_halted,
  input wire logic irq_service_ok,
  input wire logic adc_start_conv,
  input wire logic [7:0] input_buf_en,
  input wire logic [1:0] active_mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic running;
  logic [1:0] sel;
  logic [1:0] eff;
  // core_halted lags clk_cpu_en by a cycle on wake, so run needs both
  assign running = !core_halted && clk_cpu_en;
  assign sel = core_control_register[MODE_SELECT_HI_BIT -: 2];
  assign eff = (sel == 2'b11 && !crystal_clock_option) ? 2'b10 : sel;
  sequence s_taken;
    running && sleep_instr && core_control_register[SLEEP_ENABLE_BIT];
  endsequence
  sequence s_idle_quiet;
    core_halted && !clk_cpu_en && active_mode == 2'b00 && !any_irq_pending;
  endsequence
  chk_entry_halts: assert property (
    s_taken |-> ##2 (core_halted && !clk_cpu_en && !clk_flash_en)) else $error("no halt");
  chk_no_enable: assert property (
    running && sleep_instr && !core_control_register[SLEEP_ENABLE_BIT] |-> ##2 !core_halted)
    else $error("slept without enable");
  chk_mode_latch: assert property (
    s_taken |-> ##2 active_mode == $past(eff, 2)) else $error("wrong mode latched");
  chk_idle_gating: assert property (
    s_taken and eff == 2'b00 |-> ##2 (clk_io_en && clk_adc_en && osc_en)) else $error("idle");
  chk_nr_gating: assert property (
    s_taken and eff == 2'b01 |-> ##2 (!clk_io_en && clk_adc_en && osc_en)) else $error("nr");
  chk_pd_gating: assert property (
    s_taken and eff == 2'b10 |-> ##2 !(clk_io_en || clk_adc_en || osc_en)) else $error("pd");
  chk_standby_osc: assert property (
    s_taken and eff == 2'b11 |-> ##2 (osc_en && !clk_io_en && !clk_adc_en)) else $error("sb");
  chk_auto_conv: assert property (
    s_taken and adc_enable && !sel[1] |-> ##1 adc_start_conv) else $error("no conversion");
  chk_wake_bound: assert property (
    s_idle_quiet ##1 any_irq_pending [*5] |-> ##[0:3] (clk_cpu_en && irq_service_ok))
    else $error("idle wake too slow");
  chk_halt_hold: assert property (
    s_idle_quiet ##1 any_irq_pending |-> !clk_cpu_en [*4]) else $error("halt too short");
  // buffers follow the mask only while both io and converter clocks rest
  chk_buffers_off: assert property (
    !clk_io_en && !clk_adc_en && $stable(wake_pin_mask) |-> input_buf_en == wake_pin_mask)
    else $error("input buffers wrong");
endmodule
bind sleep_ctrl sleep_ctrl_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.clk_sys, .nrst,
  .core_control_register, .sleep_instr, .any_irq_pending, .crystal_clock_option, .adc_enable,
  .wake_pin_mask, .clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_adc_en, .osc_en, .core_halted,
  .irq_service_ok, .adc_start_conv, .input_buf_en, .active_mode);

// >>> tb/core_side_model.sv
// core side model: sleep opcode issue and watchdog oscillator ticks
// assumes the controller shares clk_sys; tick period is nominal only
`timescale 1ns/1ps
module core_side_model
  import sleep_ctrl_pkg::*;
(
  input wire logic clk_sys,
  output logic sleep_instr,
  output logic [7:0] core_control_register,
  output logic wd_tick
);
  // flag written just before the opcode, cleared after, so no stray sleep
  task automatic go_sleep(input logic se, input logic [1:0] mode);
    @(posedge clk_sys);
    #1;
    core_control_register = CORE_CTRL_RESET;
    core_control_register[SLEEP_ENABLE_BIT] = se;
    core_control_register[MODE_SELECT_HI_BIT -: 2] = mode;
    sleep_instr = 1'b1;
    @(posedge clk_sys);
    #1;
    sleep_instr = 1'b0;
    core_control_register = CORE_CTRL_RESET;
  endtask
  // free-running oscillator, ignores reset like the real one
  initial
  begin
    sleep_instr = 1'b0;
    core_control_register = CORE_CTRL_RESET;
    wd_tick = 1'b0;
    forever
    begin
      repeat (WDOG_TICK_CYCLES - 1) @(posedge clk_sys);
      #1 wd_tick = 1'b1;
      @(posedge clk_sys);
      #1 wd_tick = 1'b0;
    end
  end
endmodule

// >>> tb/sleep_ctrl_tb_top.sv
// self-checking bench for sleep_ctrl
// core side from core_side_model, wake sources driven here
`timescale 1ns/1ps
module sleep_ctrl_tb_top;
  import sleep_ctrl_pkg::*;
  localparam int unsigned STARTUP = 4;
  localparam logic [5:0] DECOY [4] = '{6'h00, 6'h20, 6'h34, 6'h34};
  localparam logic [5:0] WAKE [8] = '{6'h20, 6'h10, 6'h08, 6'h02, 6'h20, 6'h04, 6'h01, 6'h08};
  logic clk_sys, nrst, wake_reset, crystal_clock_option, adc_enable, sleep_instr, wd_tick;
  logic comparator_disable_bit, comparator_uses_ref, brownout_fuse_enable, watchdog_enable;
  logic any_irq_pending, irq_adc_done, irq_usi_start, irq_nvm_ready, pin_change_irq;
  logic external_interrupt_pin_level, clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, osc_en;
  logic core_halted, irq_service_ok, resume_at_reset, adc_start_conv, adc_power;
  logic adc_extended_conv, comparator_power, brownout_power, watchdog_run, vref_power;
  logic [7:0] core_control_register, wake_pin_mask, input_buf_en;
  logic [1:0] active_mode;
  logic [5:0] src_v;
  logic halted_q, conv_q, svc_seen, ext_exp;
  logic [5:0] exp_q[$];
  int fails, n_compared, cycles;
  assign {any_irq_pending, irq_adc_done, irq_usi_start, irq_nvm_ready} = src_v[5:2];
  assign {external_interrupt_pin_level, pin_change_irq} = src_v[1:0];
  sleep_ctrl #(.STARTUP_CYCLES(STARTUP)) dut (.clk_sys, .nrst, .core_control_register,
    .sleep_instr, .any_irq_pending, .irq_adc_done, .irq_usi_start, .irq_nvm_ready,
    .external_interrupt_pin_level, .pin_change_irq, .wake_reset, .wd_tick, .crystal_clock_option,
    .adc_enable, .comparator_disable_bit, .comparator_uses_ref, .brownout_fuse_enable,
    .watchdog_enable, .wake_pin_mask, .clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_adc_en,
    .osc_en, .core_halted, .irq_service_ok, .resume_at_reset, .adc_start_conv, .adc_power,
    .adc_extended_conv, .comparator_power, .brownout_power, .watchdog_run, .vref_power,
    .input_buf_en, .active_mode);
  core_side_model u_core (.clk_sys, .sleep_instr, .core_control_register, .wd_tick);
  // ****************
  // helpers
  // ****************
  // ****************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // note the expected gating before the opcode goes out
  task automatic enter(input logic [1:0] eff, input logic [1:0] sel);
    exp_q.push_back({eff, eff == 2'b00, !eff[1], eff != 2'b10, adc_enable & !eff[1]});
    u_core.go_sleep(1'b1, sel);
  endtask
  task automatic check_powers(input logic deep);
    logic cmp;
    logic [4:0] e;
    cmp = !comparator_disable_bit;
    e = {adc_enable, cmp & (!deep | comparator_uses_ref), brownout_fuse_enable, watchdog_enable,
      brownout_fuse_enable | adc_enable | (cmp & comparator_uses_ref)};
    check({adc_power, comparator_power, brownout_power, watchdog_run, vref_power}, e);
    check(input_buf_en, deep ? wake_pin_mask : 8'hFF);
  endtask
  // decoys must not wake; listed source must; usi-start wake takes start-up plus halt, up to four cycles more
  task automatic sleep_cycle(input int i);
    logic [1:0] eff;
    int s;
    int lat;
    logic adc_new;
    eff = (i[1:0] == 2'b11 && !i[2]) ? 2'b10 : i[1:0];
    s = (eff == 2'b11) ? STANDBY_WAKE_CYCLES : STARTUP;
    crystal_clock_option = i[2];
    adc_new = (i < 2) | 1'($urandom_range(1));
    // off-then-on arms an extended conversion
    ext_exp = ext_exp | (adc_new & !adc_enable);
    adc_enable = adc_new;
    step(2);
    enter(eff, i[1:0]);
    step(8);
    src_v = DECOY[eff];
    step(20);
    check({core_halted, clk_cpu_en}, 2'b10);
    check_powers(eff[1]);
    src_v = WAKE[i];
    svc_seen = 1'b0;
    lat = 0;
    while (core_halted === 1'b1 && lat < 400)
    begin
      step(1);
      lat++;
    end
    src_v = 6'h00;
    check({core_halted, resume_at_reset, svc_seen}, 3'b001);
    if (adc_enable && !eff[1])
      ext_exp = 1'b0;
    check(adc_extended_conv, ext_exp);
    if (WAKE[i] == 6'h08)
      check(lat >= s + WAKE_HALT_CYCLES && lat <= s + WAKE_HALT_CYCLES + 4, 1'b1);
  endtask
  // ****************
  // monitor and clock
  // ****************
  always @(negedge clk_sys)
  begin
    if (irq_service_ok === 1'b1)
      svc_seen = 1'b1;
    if (nrst === 1'b1 && core_halted === 1'b1 && halted_q === 1'b0)
      check({active_mode, clk_io_en, clk_adc_en, osc_en, conv_q}, exp_q.pop_front());
    halted_q = core_halted;
    conv_q = adc_start_conv;
  end
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard, run needs about 670 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    {nrst, wake_reset, crystal_clock_option, adc_enable, halted_q, conv_q, svc_seen} = 7'h00;
    src_v = 6'h00;
    ext_exp = 1'b1;
    void'($urandom(32'h0B94));
    wake_pin_mask = 8'($urandom);
    {comparator_disable_bit, comparator_uses_ref, brownout_fuse_enable, watchdog_enable} = 4'($urandom);
    step(6);
    nrst = 1'b1;
    step(1);
    check({clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, osc_en, core_halted, resume_at_reset}, 8'h7D);
    check_powers(1'b0);
    u_core.go_sleep(1'b0, 2'b10);
    step(4);
    check(core_halted, 1'b0);
    for (int i = 0; i < 8; i++)
      sleep_cycle(i);
    // short level pulse in power-down: falls between watchdog ticks, no sample, no wake
    crystal_clock_option = 1'b0;
    enter(2'b10, 2'b10);
    step(8);
    src_v = 6'h02;
    step(3);
    src_v = 6'h00;
    svc_seen = 1'b0;
    step(150);
    check({core_halted, svc_seen}, 2'b10);
    wake_reset = 1'b1;
    step(2);
    check(resume_at_reset, 1'b1);
    wake_reset = 1'b0;
    step(2);
    check(resume_at_reset, 1'b0);
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    step(1);
    check({core_halted, clk_cpu_en, resume_at_reset}, 3'b011);
    summarize();
  end
endmodule
